// File: bench/tmc_pin_load.sv
// Load circuit on the two compare pins
`timescale 1ns/1ps
`default_nettype none

module tmc_pin_load
(
    input  wire logic pin_a_i,
    input  wire logic oe_a_i,
    input  wire logic pin_b_i,
    input  wire logic oe_b_i,
    output logic      line_a_o,
    output logic      line_b_o
);
    // Pull-downs hold an undriven line low
    assign line_a_o = oe_a_i ? pin_a_i : 1'b0;
    assign line_b_o = oe_b_i ? pin_b_i : 1'b0;
endmodule

`default_nettype wire

// File: bench/tmc_timer_assertions.sv
// Bus, readback and pin-enable checks on the timer ports
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"

module tmc_timer_chk
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        compare_out_a_pin_oe_o,
    input wire logic        compare_out_b_pin_oe_o
);
    // One clock domain, quiet in reset
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic port_ack;
    logic mask_clr;

    ////////////////////////
    // Writes accepted at this edge
    assign port_ack = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `TMC_OFS_PORT;
    assign mask_clr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `TMC_OFS_MASK
                      && wb_dat_i[2:0] == 3'h0;

    ////////////////////////
    // Handshake and read data
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_RSVD_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `TMC_OFS_CTRL_A |->
        wb_dat_o[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");
    AST_HIGH_ZERO: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read lanes nonzero");
    AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1f |-> wb_dat_o == 32'h0)
        else $error("unmapped read nonzero");

    ////////////////////////
    // Pin enables follow the direction bits, interrupt follows the mask
    AST_OE_A: assert property (port_ack |-> ##2 compare_out_a_pin_oe_o == $past(wb_dat_i[0], 2))
        else $error("pin A enable differs from direction bit");
    AST_OE_B: assert property (port_ack |-> ##2 compare_out_b_pin_oe_o == $past(wb_dat_i[1], 2))
        else $error("pin B enable differs from direction bit");
    AST_OE_CAUSE: assert property ($changed(compare_out_a_pin_oe_o) ||
        $changed(compare_out_b_pin_oe_o) |-> $past(port_ack) || $past(port_ack, 2))
        else $error("pin enable moved without a port write");
    AST_IRQ_OFF: assert property (mask_clr |-> ##2 !irq_o [*4])
        else $error("interrupt high with all sources masked");
endmodule

bind tmc_timer tmc_timer_chk chk (.*);

`default_nettype wire

// File: bench/tmc_timer_tb.sv
// Self-checking bench for the timer compare-output block
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"

module tmc_timer_tb;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic        compare_out_a_pin_o, compare_out_a_pin_oe_o, line_a;
    logic        compare_out_b_pin_o, compare_out_b_pin_oe_o, line_b;
    logic [7:0]  wb_adr_i, q;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    int          bad_count, compares, m, a, c, top, x, w, hi;
    // Mode, actions A and B, port nibble, channel and top flag
    logic [15:0] tc [23] = '{
        16'h0430, 16'h0870, 16'h0070,
        16'h0332, 16'h2132,
        16'h2431,
        16'h3830, 16'h3c30,
        16'h3831, 16'h7831,
        16'h3470, 16'h7431,
        16'h1830, 16'h1c30,
        16'h5c31, 16'h5233,
        16'h5332, 16'h5232, 16'h1132,
        16'h3232, 16'h7332, 16'h31b2,
        16'h7233
    };

    tmc_timer uut (.*);
    tmc_pin_load load (.pin_a_i(compare_out_a_pin_o), .oe_a_i(compare_out_a_pin_oe_o),
        .pin_b_i(compare_out_b_pin_o), .oe_b_i(compare_out_b_pin_oe_o),
        .line_a_o(line_a), .line_b_o(line_b));

    ////////////////////////
    // 10 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Counted comparison
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %0h seen %0h", n, e, g);
            bad_count++;
        end
    endtask

    // Classic Wishbone cycle; request held to the rising edge that sees ack, data taken there
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= wr;
        wb_sel_i <= 4'h1;
        wb_adr_i <= ad;
        wb_dat_i <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        chk("ack", 32'h1, {31'h0, wb_ack_o});
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Count cycles with the line high
    task automatic meas(input logic ch, input int n);
        hi = 0;
        repeat (n)
        begin
            @(negedge clk_i);
            if ((ch ? line_b : line_a) === 1'b1)
                hi++;
        end
        @(posedge clk_i);
    endtask

    // High cycles over two periods for mode, action, channel, port bit
    function automatic int exp_hi(int md, int ac, int ch, int pb, int wn, int xv);
        if (ac == 0 || (ac == 1 && md[0] && (ch == 1 || md < 4)))
            return pb ? wn : 0;
        if (ac == 1)
            return wn / 2;
        if (md == 3 || md == 7)
            return ac == 2 ? 2 * (xv + 1) : wn - 2 * (xv + 1);
        if (md[0])
            return ac == 2 ? 4 * xv : wn - 4 * xv;
        return ac == 2 ? 0 : wn;
    endfunction

    ////////////////////////
    // Main sequence
    initial
    begin
        bad_count = 0;
        compares = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0;
        void'($urandom(32'hdb5a));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b0, 8'(i * 4), 8'h00);
            chk("reset value", 32'h0, {24'h0, q});
        end
        bus(1'b1, `TMC_OFS_CTRL_A, 8'hff);
        bus(1'b0, `TMC_OFS_CTRL_A, 8'h00);
        chk("control a", 32'hf3, {24'h0, q});
        $display("register test done");
        bus(1'b1, `TMC_OFS_CTRL_A, 8'h00);
        bus(1'b1, `TMC_OFS_CTRL_B, 8'h01);
        repeat (300) @(negedge clk_i);
        chk("irq masked", 32'h0, {31'h0, irq_o});
        @(posedge clk_i);
        bus(1'b0, `TMC_OFS_STATUS, 8'h00);
        chk("overflow flag", 32'h1, {31'h0, q[0]});
        bus(1'b1, `TMC_OFS_MASK, 8'h01);
        @(negedge clk_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        @(posedge clk_i);
        bus(1'b1, `TMC_OFS_CTRL_B, 8'h00);
        bus(1'b1, `TMC_OFS_STATUS, 8'h07);
        @(negedge clk_i);
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        @(posedge clk_i);
        bus(1'b1, `TMC_OFS_MASK, 8'h00);
        $display("interrupt test done");
        foreach (tc[i])
        begin
            c = tc[i][1];
            m = tc[i][14:12];
            a = c ? tc[i][9:8] : tc[i][11:10];
            top = (m == 2 || m == 5 || m == 7) ? 20 + $urandom % 41 : 255;
            x = tc[i][0] ? top : 1 + $urandom % (top - 1);
            w = (m == 1 || m == 5) ? 4 * top : 2 * (top + 1);
            bus(1'b1, `TMC_OFS_CTRL_B, 8'h00);
            bus(1'b1, `TMC_OFS_COUNT, 8'h00);
            bus(1'b1, `TMC_OFS_CMP_A, 8'(c ? top : x));
            bus(1'b1, `TMC_OFS_CMP_B, 8'(x));
            bus(1'b1, `TMC_OFS_PORT, {4'h0, tc[i][7:4]});
            bus(1'b1, `TMC_OFS_CTRL_A, {tc[i][11:8], 2'b00, tc[i][13:12]});
            bus(1'b1, `TMC_OFS_CTRL_B, {4'h0, tc[i][14], 3'b001});
            repeat (1100) @(posedge clk_i);
            meas(c[0], w);
            chk("pin high cycles", exp_hi(m, a, c, tc[i][6 + c], w, x), hi);
            $display("wave case %0d done", i);
        end
        close_out();
    end

    // Cut a hang short
    initial
    begin
        #(100 * 90000);
        bad_count++;
        close_out();
    end
endmodule

`default_nettype wire

// File: rtl/tmc_defines.svh
// Register offsets, field positions, reset values and counts of the timer
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Word-aligned byte offsets on the Wishbone bus
`define TMC_OFS_CTRL_A      8'h00
`define TMC_OFS_CTRL_B      8'h04
`define TMC_OFS_COUNT       8'h08
`define TMC_OFS_CMP_A       8'h0c
`define TMC_OFS_CMP_B       8'h10
`define TMC_OFS_STATUS      8'h14
`define TMC_OFS_MASK        8'h18
`define TMC_OFS_PORT        8'h1c

// Fields of timer_control_a
`define TMC_A_ACT_HI        7
`define TMC_A_ACT_LO        6
`define TMC_B_ACT_HI        5
`define TMC_B_ACT_LO        4
`define TMC_MODE_LO_HI      1
`define TMC_MODE_LO_LO      0
`define TMC_CTRL_A_WMASK    8'hf3

// Fields of timer_control_b
`define TMC_MODE_HI_BIT     3
`define TMC_CLK_SEL_HI      2
`define TMC_CLK_SEL_LO      0
`define TMC_CTRL_B_WMASK    8'h0f

// Status and mask bits
`define TMC_ST_OVF          0
`define TMC_ST_MATCH_A      1
`define TMC_ST_MATCH_B      2
`define TMC_ST_WMASK        8'h07

// Port register bits: direction and plain port level
`define TMC_PORT_DIR_A      0
`define TMC_PORT_DIR_B      1
`define TMC_PORT_DAT_A      2
`define TMC_PORT_DAT_B      3
`define TMC_PORT_WMASK      8'h0f

// Counter limits and reset values
`define TMC_MAX             8'hff
`define TMC_BOTTOM          8'h00
`define TMC_RST_BYTE        8'h00

`endif

// File: rtl/tmc_pkg.sv
// Types shared by the timer compare-output control block
`default_nettype none

package tmc_pkg;

    // Waveform family selected by the three mode bits
    typedef enum logic [1:0] {
        WV_NORMAL = 2'b00,
        WV_CTC    = 2'b01,
        WV_FAST   = 2'b11,
        WV_PHASE  = 2'b10
    } tmc_wave_e;

    // Decoded mode
    typedef struct packed {
        tmc_wave_e wave;
        logic      top_is_a;
    } tmc_mode_s;

    // Whole state of the timer block
    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [7:0]  count;
        logic        count_up;
        logic        blk;
        logic [7:0]  cmp_a_buf;
        logic [7:0]  cmp_b_buf;
        logic [7:0]  cmp_a_act;
        logic [7:0]  cmp_b_act;
        logic [7:0]  status;
        logic [7:0]  mask;
        logic [7:0]  port;
        logic        oc_a;
        logic        oc_b;
        logic        pin_a;
        logic        pin_b;
        logic        oe_a;
        logic        oe_b;
        logic        irq;
        logic        ack;
        logic [31:0] rdata;
    } tmc_state_s;

endpackage

`default_nettype wire

// File: rtl/tmc_timer.sv
// 8-bit timer with compare-output mode control and a Wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_defines.svh"

module tmc_timer
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             compare_out_a_pin_o,
    output logic             compare_out_a_pin_oe_o,
    output logic             compare_out_b_pin_o,
    output logic             compare_out_b_pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Mode decode from the three mode bits
    function automatic tmc_pkg::tmc_mode_s decode_mode(input logic [2:0] sel);
        tmc_pkg::tmc_mode_s m;
        m.top_is_a = 1'b0;
        m.wave     = tmc_pkg::WV_NORMAL;
        unique case (sel)
            3'h1:
            begin
                m.wave = tmc_pkg::WV_PHASE;
            end
            3'h2:
            begin
                m.wave     = tmc_pkg::WV_CTC;
                m.top_is_a = 1'b1;
            end
            3'h3:
            begin
                m.wave = tmc_pkg::WV_FAST;
            end
            3'h5:
            begin
                m.wave     = tmc_pkg::WV_PHASE;
                m.top_is_a = 1'b1;
            end
            3'h7:
            begin
                m.wave     = tmc_pkg::WV_FAST;
                m.top_is_a = 1'b1;
            end
            default:
            begin
                m.wave = tmc_pkg::WV_NORMAL; // Modes 0, 4 and 6 count as normal
            end
        endcase
        return m;
    endfunction

    // Next compare output level of one channel
    function automatic logic wave_next(
        input logic               oc,
        input logic [1:0]         act,
        input tmc_pkg::tmc_wave_e wave,
        input logic               mode_hi,
        input logic               chan_a,
        input logic               match,
        input logic               cmp_is_top,
        input logic               up,
        input logic               wrap,
        input logic               at_top
    );
        logic nx;
        logic hit;
        nx  = oc;
        hit = match & ~(act[1] & cmp_is_top);
        if (wave == tmc_pkg::WV_NORMAL || wave == tmc_pkg::WV_CTC)
        begin
            if (match)
            begin
                unique case (act)
                    2'b01:   nx = ~oc;
                    2'b10:   nx = 1'b0;
                    2'b11:   nx = 1'b1;
                    default: nx = oc;
                endcase
            end
        end
        else if (act == 2'b01)
        begin
            if (chan_a && mode_hi && match)
            begin
                nx = ~oc;
            end
        end
        else if (act[1] && wave == tmc_pkg::WV_FAST)
        begin
            if (wrap)
            begin
                nx = ~act[0];
            end
            else if (hit)
            begin
                nx = act[0];
            end
        end
        else if (act[1])
        begin
            if (cmp_is_top && at_top)
            begin
                nx = ~act[0];
            end
            else if (hit)
            begin
                nx = up ? act[0] : ~act[0];
            end
        end
        return nx;
    endfunction

    // Pin ownership: waveform only for a live action code
    function automatic logic pin_owned(input logic [1:0] act, input logic chan_a,
                                       input tmc_pkg::tmc_wave_e wave, input logic mode_hi);
        logic own;
        own = (act != 2'b00);
        if (act == 2'b01 && (wave == tmc_pkg::WV_FAST || wave == tmc_pkg::WV_PHASE))
        begin
            own = chan_a & mode_hi;
        end
        return own;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    tmc_pkg::tmc_state_s st_r;
    tmc_pkg::tmc_state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    // Bus, counter, compare units, flags and pins
    always_comb
    begin
        tmc_pkg::tmc_mode_s mode;
        logic       run;
        logic [7:0] top;
        logic       at_top;
        logic       wrap;
        logic       match_a;
        logic       match_b;
        logic       ovf;
        logic       acc;
        logic       wr;
        logic [7:0] wd;
        logic [7:0] clr;
        logic [7:0] ev;
        logic [1:0] act_a;
        logic [1:0] act_b;
        logic       mode_hi;

        st_nxt  = st_r;
        mode    = decode_mode({st_r.ctrl_b[`TMC_MODE_HI_BIT],
                               st_r.ctrl_a[`TMC_MODE_LO_HI:`TMC_MODE_LO_LO]});
        mode_hi = st_r.ctrl_b[`TMC_MODE_HI_BIT];
        act_a   = st_r.ctrl_a[`TMC_A_ACT_HI:`TMC_A_ACT_LO];
        act_b   = st_r.ctrl_a[`TMC_B_ACT_HI:`TMC_B_ACT_LO];
        run     = (st_r.ctrl_b[`TMC_CLK_SEL_HI:`TMC_CLK_SEL_LO] != 3'h0);
        top     = mode.top_is_a ? st_r.cmp_a_act : `TMC_MAX;
        at_top  = (st_r.count == top);
        wrap    = run & at_top & (mode.wave == tmc_pkg::WV_FAST);
        match_a = run & ~st_r.blk & (st_r.count == st_r.cmp_a_act);
        match_b = run & ~st_r.blk & (st_r.count == st_r.cmp_b_act);
        ovf     = 1'b0;
        acc     = wb_cyc_i & wb_stb_i;
        wr      = acc & wb_we_i & st_r.ack & wb_sel_i[0];
        wd      = wb_dat_i[7:0];
        clr     = 8'h00;
        ev      = 8'h00;
        st_nxt.blk = 1'b0;

        // Counter sequence per waveform family
        if (run)
        begin
            unique case (mode.wave)
                tmc_pkg::WV_FAST:
                begin
                    st_nxt.count = at_top ? `TMC_BOTTOM : st_r.count + 8'h01;
                    ovf = mode.top_is_a ? at_top : (st_r.count == `TMC_MAX);
                end
                tmc_pkg::WV_PHASE:
                begin
                    if (st_r.count_up)
                    begin
                        st_nxt.count_up = ~at_top;
                        st_nxt.count    = at_top ? st_r.count - 8'h01
                                                 : st_r.count + 8'h01;
                    end
                    else
                    begin
                        st_nxt.count_up = (st_r.count == `TMC_BOTTOM);
                        st_nxt.count    = st_nxt.count_up ? st_r.count + 8'h01
                                                          : st_r.count - 8'h01;
                        ovf = (st_r.count == `TMC_BOTTOM);
                    end
                end
                tmc_pkg::WV_CTC:
                begin
                    st_nxt.count = at_top ? `TMC_BOTTOM : st_r.count + 8'h01;
                    ovf = (st_r.count == `TMC_MAX);
                end
                default:
                begin
                    st_nxt.count = st_r.count + 8'h01;
                    ovf = (st_r.count == `TMC_MAX);
                end
            endcase
        end

        // Compare register update moment
        unique case (mode.wave)
            tmc_pkg::WV_FAST:
            begin
                if (wrap)
                begin
                    st_nxt.cmp_a_act = st_r.cmp_a_buf;
                    st_nxt.cmp_b_act = st_r.cmp_b_buf;
                end
            end
            tmc_pkg::WV_PHASE:
            begin
                if (run && at_top && st_r.count_up)
                begin
                    st_nxt.cmp_a_act = st_r.cmp_a_buf;
                    st_nxt.cmp_b_act = st_r.cmp_b_buf;
                end
            end
            default:
            begin
                st_nxt.cmp_a_act = st_r.cmp_a_buf;
                st_nxt.cmp_b_act = st_r.cmp_b_buf;
            end
        endcase

        // Waveform generators
        st_nxt.oc_a = wave_next(st_r.oc_a, act_a, mode.wave, mode_hi, 1'b1, match_a,
                                st_r.cmp_a_act == top, st_r.count_up, wrap,
                                run & at_top);
        st_nxt.oc_b = wave_next(st_r.oc_b, act_b, mode.wave, mode_hi, 1'b0, match_b,
                                st_r.cmp_b_act == top, st_r.count_up, wrap,
                                run & at_top);

        // Wishbone classic slave: ack one cycle after the request
        st_nxt.ack   = acc & ~st_r.ack;
        st_nxt.rdata = 32'h0000_0000;
        if (acc && !st_r.ack && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `TMC_OFS_CTRL_A: st_nxt.rdata[7:0] = st_r.ctrl_a & `TMC_CTRL_A_WMASK;
                `TMC_OFS_CTRL_B: st_nxt.rdata[7:0] = st_r.ctrl_b;
                `TMC_OFS_COUNT:  st_nxt.rdata[7:0] = st_r.count;
                `TMC_OFS_CMP_A:  st_nxt.rdata[7:0] = st_r.cmp_a_buf;
                `TMC_OFS_CMP_B:  st_nxt.rdata[7:0] = st_r.cmp_b_buf;
                `TMC_OFS_STATUS: st_nxt.rdata[7:0] = st_r.status;
                `TMC_OFS_MASK:   st_nxt.rdata[7:0] = st_r.mask;
                `TMC_OFS_PORT:   st_nxt.rdata[7:0] = st_r.port;
                default:         st_nxt.rdata      = 32'h0000_0000;
            endcase
        end

        // Register writes on the edge the master sees ack
        if (wr)
        begin
            unique case (wb_adr_i)
                `TMC_OFS_CTRL_A: st_nxt.ctrl_a = wd & `TMC_CTRL_A_WMASK;
                `TMC_OFS_CTRL_B: st_nxt.ctrl_b = wd & `TMC_CTRL_B_WMASK;
                `TMC_OFS_COUNT:
                begin
                    st_nxt.count = wd;
                    st_nxt.blk   = 1'b1; // Written count blocks the next match
                end
                `TMC_OFS_CMP_A:  st_nxt.cmp_a_buf = wd;
                `TMC_OFS_CMP_B:  st_nxt.cmp_b_buf = wd;
                `TMC_OFS_STATUS: clr = wd & `TMC_ST_WMASK;
                `TMC_OFS_MASK:   st_nxt.mask = wd & `TMC_ST_WMASK;
                `TMC_OFS_PORT:   st_nxt.port = wd & `TMC_PORT_WMASK;
                default:         clr = 8'h00;
            endcase
        end

        // Sticky flags: a new event wins over a clear in the same cycle
        ev[`TMC_ST_OVF]     = ovf;
        ev[`TMC_ST_MATCH_A] = match_a;
        ev[`TMC_ST_MATCH_B] = match_b;
        st_nxt.status = (st_r.status & ~clr) | ev;
        st_nxt.irq    = |(st_nxt.status & st_nxt.mask);

        // Pin mux: waveform when owned, else plain port level
        st_nxt.pin_a = pin_owned(act_a, 1'b1, mode.wave, mode_hi)
                       ? st_nxt.oc_a : st_nxt.port[`TMC_PORT_DAT_A];
        st_nxt.pin_b = pin_owned(act_b, 1'b0, mode.wave, mode_hi)
                       ? st_nxt.oc_b : st_nxt.port[`TMC_PORT_DAT_B];
        st_nxt.oe_a  = st_nxt.port[`TMC_PORT_DIR_A];
        st_nxt.oe_b  = st_nxt.port[`TMC_PORT_DIR_B];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset clears everything; counter starts counting up
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r          <= '0;
            st_r.count_up <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state flops

    assign wb_dat_o               = st_r.rdata;
    assign wb_ack_o               = st_r.ack;
    assign irq_o                  = st_r.irq;
    assign compare_out_a_pin_o    = st_r.pin_a;
    assign compare_out_a_pin_oe_o = st_r.oe_a;
    assign compare_out_b_pin_o    = st_r.pin_b;
    assign compare_out_b_pin_oe_o = st_r.oe_b;

endmodule

`default_nettype wire
